// file: rtl/tsp_pkg.sv
package tsp_pkg;
   // =====================================================
   // link framing
   localparam int BYTE_BITS = 8;
   localparam logic [2:0] BIT_CNT_RST = 3'h0;
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic IRQ_IDLE = 1'b1;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam int FIFO_DEPTH_DEF = 8;

   // =====================================================
   // byte carrier across the domains
   typedef struct packed
   {
      logic [7:0] data;
      logic first;
   } tsp_byte_s;

   typedef enum logic [1:0]
   {
      TSP_IDLE,
      TSP_ACTIVE
   } tsp_state_e;
endpackage : tsp_pkg

// file: rtl/tsp_fifo.sv
`timescale 1ns/1ps
// dual-clock fifo with gray pointers
module tsp_fifo
   import tsp_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
)
(
   input wire logic wr_clk, // write clock
   input wire logic wr_rst, // write reset
   input wire logic wr_valid, // write request
   output logic wr_ready, // space left
   input wire logic [WIDTH-1:0] wr_data, // write word
   input wire logic rd_clk, // read clock
   input wire logic rd_rst, // read reset
   output logic rd_valid, // word present
   input wire logic rd_ready, // reader takes word
   output logic [WIDTH-1:0] rd_data // read word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [AW:0] wg_reg, rg_reg;
   logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
   logic [WIDTH-1:0] rd_data_reg, rd_data_next;

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : bin2gray

   // =====================================================
   // write side
   assign wr_ready = (wg_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]});
   always_comb
   begin
      wptr_next = wptr_reg;
      if (wr_valid && wr_ready)
         wptr_next = wptr_reg + 1'b1;
   end
   always_ff @(posedge wr_clk or posedge wr_rst)
   begin
      if (wr_rst)
      begin
         wptr_reg <= '0;
         wg_reg <= '0;
         rg_s1_reg <= '0;
         rg_s2_reg <= '0;
      end
      else
      begin
         wptr_reg <= wptr_next;
         wg_reg <= bin2gray(wptr_next);
         rg_s1_reg <= rg_reg;
         rg_s2_reg <= rg_s1_reg;
      end
   end
   // storage written without reset
   always_ff @(posedge wr_clk)
   begin
      if (wr_valid && wr_ready)
         mem_reg[wptr_reg[AW-1:0]] <= wr_data;
   end

   // =====================================================
   // read side, data out of a register
   logic rd_valid_reg, rd_valid_next;
   logic fifo_has;
   assign fifo_has = (rg_reg != wg_s2_reg);
   assign rd_valid = rd_valid_reg;
   assign rd_data = rd_data_reg;
   always_comb
   begin
      rptr_next = rptr_reg;
      rd_valid_next = rd_valid_reg;
      rd_data_next = rd_data_reg;
      if (rd_valid_reg && rd_ready)
         rd_valid_next = 1'b0;
      if (fifo_has && (!rd_valid_reg || rd_ready))
      begin
         rd_data_next = mem_reg[rptr_reg[AW-1:0]];
         rd_valid_next = 1'b1;
         rptr_next = rptr_reg + 1'b1;
      end
   end
   always_ff @(posedge rd_clk or posedge rd_rst)
   begin
      if (rd_rst)
      begin
         rptr_reg <= '0;
         rg_reg <= '0;
         wg_s1_reg <= '0;
         wg_s2_reg <= '0;
         rd_valid_reg <= 1'b0;
         rd_data_reg <= '0;
      end
      else
      begin
         rptr_reg <= rptr_next;
         rg_reg <= bin2gray(rptr_next);
         wg_s1_reg <= wg_reg;
         wg_s2_reg <= wg_s1_reg;
         rd_valid_reg <= rd_valid_next;
         rd_data_reg <= rd_data_next;
      end
   end
endmodule : tsp_fifo

// file: rtl/tsp_port.sv
`timescale 1ns/1ps
// Behaviour
// [RQ1] The link uses clock polarity zero and phase one on every transfer.
// [RQ2] The master always uses the select line; three-wire mode is not supported.
// [RQ3] The first rising serial clock edge of an access releases the interrupt output.
// [RQ4] Every byte moves most significant bit first in both directions.
// [RQ5] Transfers are whole bytes; each eight clocked bits form one unit.
// [RQ6] Select going high then low at a byte boundary ends the access after that byte.
// [RQ7] Output updates after each rising edge; input is sampled on each falling edge.
module tsp_port
   import tsp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH_DEF
)
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, high
   input wire logic sclk, // serial clock from master
   input wire logic serial_select_low, // select, active low
   input wire logic mosi, // data from master
   output logic miso, // data to master
   output logic miso_oe, // miso drive enable
   output logic irq_out_low, // interrupt, active low
   input wire logic irq_set, // core event raises interrupt
   output logic rx_valid, // received byte present
   input wire logic rx_ready, // core takes byte
   output logic [7:0] rx_data, // received byte
   output logic rx_first, // byte opens an access
   input wire logic [7:0] tx_data, // next byte to send
   output logic tx_take // pulse: tx_data taken
);
   // =====================================================
   // helpers shared by the link and core logic
   // the eighth falling edge of a byte completes it
   function automatic logic is_last_bit(input logic [2:0] cnt);
      return cnt == BIT_CNT_LAST;
   endfunction : is_last_bit

   // the rising edge at a byte boundary loads the next byte
   function automatic logic is_byte_start(input logic [2:0] cnt);
      return cnt == BIT_CNT_RST;
   endfunction : is_byte_start

   // a synchronised level that has just gone high
   function automatic logic sync_rose(input logic s2, input logic s3);
      return s2 && !s3;
   endfunction : sync_rose

   // =====================================================
   // link domain reset
   // deselect clears the shifters and bit counts at once (not the load toggle), so a cut byte never survives
   logic lrst;
   assign lrst = rst | serial_select_low; // [RQ2] [RQ6]

   // core copy of the byte to send; the core holds tx_data still around
   // a byte boundary, so the link may read this word as a static value
   logic [7:0] tx_data_hold_reg, tx_data_hold_next;

   // =====================================================
   // receive shifter: falling edge sampling, msb first [RQ1] [RQ7] [RQ4]
   logic [2:0] bcnt_reg, bcnt_next;
   logic [6:0] sh_reg, sh_next;
   logic first_reg, first_next;
   logic wr_valid, wr_ready;
   tsp_byte_s wr_word;

   // next count and shift value, and the byte offered to the fifo
   always_comb
   begin
      bcnt_next = bcnt_reg + 3'h1; // [RQ5]
      sh_next = {sh_reg[5:0], mosi};
      first_next = first_reg;
      wr_valid = 1'b0;
      wr_word.data = {sh_reg, mosi};
      wr_word.first = first_reg;
      if (is_last_bit(bcnt_reg))
      begin
         wr_valid = 1'b1; // byte complete [RQ5]
         first_next = 1'b0;
      end
   end

   // receive registers; a partial byte is lost at deselect
   always_ff @(negedge sclk or posedge lrst)
   begin
      if (lrst)
      begin
         bcnt_reg <= BIT_CNT_RST; // deselect ends access [RQ6]
         sh_reg <= '0;
         first_reg <= 1'b1;
      end
      else
      begin
         bcnt_reg <= bcnt_next;
         sh_reg <= sh_next;
         first_reg <= first_next;
      end
   end

   // =====================================================
   // transmit shifter: rising edge updates, msb first [RQ7] [RQ4]
   logic [2:0] obit_reg, obit_next;
   logic [7:0] osh_reg, osh_next;
   logic seen_reg, seen_next;

   // next output byte; the boundary edge loads the core's byte
   always_comb
   begin
      obit_next = obit_reg + 3'h1;
      osh_next = {osh_reg[6:0], 1'b0};
      seen_next = 1'b1; // first rising edge seen [RQ3]
      if (is_byte_start(obit_reg))
         osh_next = tx_data_hold_reg; // load byte at boundary [RQ5]
   end

   // transmit registers, cleared by deselect
   always_ff @(posedge sclk or posedge lrst)
   begin
      if (lrst)
      begin
         obit_reg <= BIT_CNT_RST;
         osh_reg <= BYTE_RST;
         seen_reg <= 1'b0;
      end
      else
      begin
         obit_reg <= obit_next;
         osh_reg <= osh_next;
         seen_reg <= seen_next;
      end
   end

   // miso from the shifter; the pin is driven from the first rising edge
   // until deselect, since the master samples nothing before that edge
   assign miso = osh_reg[7];
   assign miso_oe = seen_reg;

   // =====================================================
   // load toggle: one flip per byte loaded, kept across deselect
   logic take_tgl_reg, take_tgl_next;

   // flip at every boundary edge so the core can count the loads
   always_comb
   begin
      take_tgl_next = take_tgl_reg;
      if (is_byte_start(obit_reg))
         take_tgl_next = ~take_tgl_reg; // [RQ5]
   end

   // toggle register, reset only by the system reset
   always_ff @(posedge sclk or posedge rst)
   begin
      if (rst)
         take_tgl_reg <= 1'b0;
      else
         take_tgl_reg <= take_tgl_next;
   end

   // =====================================================
   // crossing fifo, link to core
   // written on the falling edge that completes a byte, so the last byte
   // of an access lands although the master stops the clock after it
   logic sclk_n;
   tsp_byte_s rd_word;
   assign sclk_n = ~sclk;
   tsp_fifo #(.WIDTH($bits(tsp_byte_s)), .DEPTH(DEPTH)) u_fifo
   (
      .wr_clk(sclk_n),
      .wr_rst(rst),
      .wr_valid(wr_valid),
      .wr_ready(wr_ready),
      .wr_data(wr_word),
      .rd_clk(clk),
      .rd_rst(rst),
      .rd_valid(rx_valid),
      .rd_ready(rx_ready),
      .rd_data(rd_word)
   );

   // received byte and its flag, both straight from the fifo register
   assign rx_data = rd_word.data;
   assign rx_first = rd_word.first;

   // =====================================================
   // core domain: synchronisers for the link's flags
   logic seen_s1_reg, seen_s2_reg, seen_s3_reg;
   logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;

   // two flops per flag, a third one to find the change
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         seen_s1_reg <= 1'b0;
         seen_s2_reg <= 1'b0;
         seen_s3_reg <= 1'b0;
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
      end
      else
      begin
         seen_s1_reg <= seen_reg;
         seen_s2_reg <= seen_s1_reg;
         seen_s3_reg <= seen_s2_reg;
         tgl_s1_reg <= take_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
      end
   end

   // =====================================================
   // core domain: interrupt, take pulse and held tx byte
   logic irq_low_reg, irq_low_next;
   logic take_reg, take_next;

   // next interrupt level, load pulse and byte to send
   always_comb
   begin
      irq_low_next = irq_low_reg;
      if (sync_rose(seen_s2_reg, seen_s3_reg))
         irq_low_next = IRQ_IDLE; // release on first rising edge [RQ3]
      if (irq_set)
         irq_low_next = ~IRQ_IDLE; // set wins over release
      take_next = tgl_s2_reg ^ tgl_s3_reg;
      tx_data_hold_next = tx_data;
   end

   // core registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         irq_low_reg <= IRQ_IDLE;
         take_reg <= 1'b0;
         tx_data_hold_reg <= BYTE_RST;
      end
      else
      begin
         irq_low_reg <= irq_low_next;
         take_reg <= take_next;
         tx_data_hold_reg <= tx_data_hold_next;
      end
   end

   // outputs straight from their registers
   assign irq_out_low = irq_low_reg;
   assign tx_take = take_reg;
endmodule : tsp_port

// file: verification/tsp_port_sva.sv
`timescale 1ns/1ps
// ==========
// port checker
module tsp_port_sva
(
   input wire logic clk, // system clock
   input wire logic rst, // reset
   input wire logic serial_select_low, // select
   input wire logic miso_oe, // drive enable
   input wire logic irq_out_low, // interrupt
   input wire logic irq_set, // raise
   input wire logic rx_valid, // byte present
   input wire logic rx_ready, // taken
   input wire logic [7:0] rx_data, // byte
   input wire logic rx_first, // first flag
   input wire logic tx_take // tx pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // no drive on miso while deselected
   a_oe_sel: assert property (serial_select_low |-> !miso_oe)
      else $error("miso driven while deselected");
   // drive starts at the first rising edge, which also releases the interrupt
   a_irq_release: assert property ($rose(miso_oe) |-> ##[2:4] irq_out_low)
      else $error("interrupt not released by access");
   // only an access releases the interrupt
   a_irq_hold: assert property (!irq_out_low && serial_select_low |=> !irq_out_low)
      else $error("interrupt released without access");
   a_irq_raise: assert property (irq_set |-> ##[1:4] !irq_out_low)
      else $error("interrupt not raised");
   // a waiting byte stands unchanged
   a_rx_stand: assert property (rx_valid && !rx_ready |=>
      rx_valid && $stable(rx_data) && $stable(rx_first))
      else $error("held byte changed");
   a_take_pulse: assert property (tx_take |=> !tx_take)
      else $error("take pulse too long");
   // no byte loads long after deselect
   a_take_idle: assert property (serial_select_low [*8] |-> !tx_take)
      else $error("take while deselected");
endmodule : tsp_port_sva

bind tsp_port tsp_port_sva u_sva (.clk(clk), .rst(rst), .serial_select_low(serial_select_low),
   .miso_oe(miso_oe), .irq_out_low(irq_out_low), .irq_set(irq_set), .rx_valid(rx_valid),
   .rx_ready(rx_ready), .rx_data(rx_data), .rx_first(rx_first), .tx_take(tx_take));

// file: verification/tsp_master_model.sv
`timescale 1ns/1ps
// ==========
// serial master model
module tsp_master_model
(
   output logic sclk, // serial clock
   output logic serial_select_low, // select
   output logic mosi, // data out
   input wire logic miso // data in
);
   // idle: clock low, deselected
   initial
   begin
      sclk = 1'b0;
      serial_select_low = 1'b1;
      mosi = 1'b0;
   end
   // select leads the first edge
   task automatic open_sel();
      serial_select_low = 1'b0;
      #15;
   endtask : open_sel
   // gap above minimum; released data line toggles
   task automatic close_sel();
      serial_select_low = 1'b1;
      mosi = ~mosi;
      #45;
   endtask : close_sel
   // n bits msb first: change after rise, sample on fall
   task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         sclk = 1'b1;
         #1 mosi = tx[i];
         #5 sclk = 1'b0;
         rx = {rx[6:0], miso};
         #6;
      end
   endtask : shift
endmodule : tsp_master_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
// ==========
// testbench top
module tb_top;
   logic clk, rst, sclk, serial_select_low, mosi, miso, miso_oe, irq_out_low, irq_set;
   logic rx_valid, rx_ready, rx_first, tx_take;
   logic [7:0] rx_data, tx_data;
   logic [8:0] rq[$];
   int failures = 0;
   int n_checks = 0;
   int takes = 0;
   int cyc = 0;

   tsp_port dut (.clk(clk), .rst(rst), .sclk(sclk), .serial_select_low(serial_select_low),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .irq_out_low(irq_out_low),
      .irq_set(irq_set), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_first(rx_first), .tx_data(tx_data), .tx_take(tx_take));
   tsp_master_model m (.sclk(sclk), .serial_select_low(serial_select_low), .mosi(mosi),
      .miso(miso));

   // clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // collect bytes, count loads, bound the run
   always @(posedge clk)
   begin
      cyc++;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rq.push_back({rx_first, rx_data});
      if (tx_take === 1'b1) takes++;
      if (cyc == 5000)
      begin
         failures++;
         final_report();
      end
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // interrupt, two-byte access both ways
   task automatic t_access();
      logic [7:0] r;
      @(negedge clk) irq_set = 1'b1;
      tx_data = 8'ha5;
      @(negedge clk) irq_set = 1'b0;
      repeat (5) @(negedge clk);
      takes = 0;
      chk(irq_out_low, 1'b0);
      m.open_sel();
      m.shift(8, 8'h3c, r);
      chk(r, 8'ha5);
      chk(irq_out_low, 1'b1);
      m.shift(8, 8'hc3, r);
      chk(r, 8'ha5);
      m.close_sel();
      repeat (10) @(negedge clk);
      chk(9'(rq.size()), 9'h002);
      chk(rq.pop_front(), 9'h13c);
      chk(rq.pop_front(), 9'h0c3);
      chk(9'(takes), 9'h002);
   endtask : t_access

   // partial byte dropped, select pulse restarts access
   task automatic t_abort();
      logic [7:0] r;
      tx_data = 8'h5a;
      m.open_sel();
      m.shift(5, 8'hff, r);
      m.close_sel();
      m.open_sel();
      m.shift(8, 8'h81, r);
      chk(r, 8'h5a);
      m.close_sel();
      m.open_sel();
      m.shift(8, 8'h42, r);
      m.close_sel();
      repeat (10) @(negedge clk);
      chk(9'(rq.size()), 9'h002);
      chk(rq.pop_front(), 9'h181);
      chk(rq.pop_front(), 9'h142);
   endtask : t_abort

   // fill past full while stalled (eight stored plus one in the output
   // register), the tenth byte is dropped, then drain
   task automatic t_fifo();
      logic [7:0] r;
      @(negedge clk) rx_ready = 1'b0;
      m.open_sel();
      for (int i = 0; i < 10; i++) m.shift(8, 8'h10 + 8'(i), r);
      m.close_sel();
      repeat (10) @(negedge clk);
      chk(rx_valid, 1'b1);
      rx_ready = 1'b1;
      repeat (20) @(negedge clk);
      chk(rx_valid, 1'b0);
      chk(9'(rq.size()), 9'h009);
      for (int i = 0; i < 9; i++) chk(rq[i], {i == 0, 8'h10 + 8'(i)});
   endtask : t_fifo

   task automatic final_report();
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   // main sequence
   initial
   begin
      rst = 1'b1;
      irq_set = 1'b0;
      rx_ready = 1'b1;
      tx_data = 8'h00;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_access();
      t_abort();
      t_fifo();
      final_report();
   end
endmodule : tb_top
